// [verification/ebct_req_sink.sv]
/*
 Request receivers: priority, transfer and conversion starts.
 Assumes requests synchronous to clk_in.
*/
`timescale 1ns/1ps
module ebct_req_sink (
    // Clock and reset
    input wire logic clk_in,
    input wire logic arst_n_in,
    // Requests from the timer unit
    input wire ebct_pkg::ebct_irq_type [1:0] irq_in,
    input wire logic [1:0] dtc_req_a_in,
    input wire logic [1:0] dtc_req_b_in,
    input wire logic adc_start_in,
    // What the receivers saw
    output logic [7:0] dtc_count_out,
    output logic [7:0] adc_count_out,
    output logic [1:0] top_source_out
);
    logic [3:0] prev_req;
    // Channel 0 winner: match A first, overflow last
    assign top_source_out = irq_in[0].match_a_irq ? 2'h1 :
        irq_in[0].match_b_irq ? 2'h2 : irq_in[0].overflow_irq ? 2'h3 : 2'h0;
    // A held level is one job: only rising transfer requests count, conversion starts count per cycle
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            prev_req <= 4'h0;
            dtc_count_out <= 8'h00;
            adc_count_out <= 8'h00;
        end else begin
            prev_req <= {dtc_req_b_in, dtc_req_a_in};
            dtc_count_out <= dtc_count_out +
                8'($countones({dtc_req_b_in, dtc_req_a_in} & ~prev_req));
            adc_count_out <= adc_count_out + {7'h00, adc_start_in};
        end
    end
endmodule : ebct_req_sink

// [verification/ebct_timer_assertions.sv]
/*
 Port checker bound onto every timer unit.
 Assumes one clock domain and an active-low async reset.
*/
`timescale 1ns/1ps
module ebct_timer_assertions #(
    parameter bit HAS_EXT_RESET = 1'b1
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic arst_n_in,
    // Register port
    input wire logic [7:0] addr_in,
    input wire logic [7:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    input wire logic [7:0] rdata_out,
    // Pins and requests
    input wire logic [1:0] timer_output_pin_out,
    input wire logic [1:0] timer_output_oe_n_out,
    input wire ebct_pkg::ebct_irq_type [1:0] irq_out,
    input wire logic [1:0] dtc_req_a_out,
    input wire logic [1:0] dtc_req_b_out,
    input wire logic adc_start_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (!arst_n_in);

    // Channel 0 enables dropped, then its three requests must fall
    sequence s_enables_off;
        wr_in && addr_in == 8'h00 && wdata_in[7:5] == 3'h0;
    endsequence
    sequence s_ch0_quiet;
        !irq_out[0].match_a_irq && !irq_out[0].match_b_irq && !irq_out[0].overflow_irq;
    endsequence

    a_pin_reset_low: assert property ($rose(arst_n_in) |->
        timer_output_pin_out == 2'h0 && timer_output_oe_n_out == 2'h3)
        else $error("output pin not idle after reset");
    a_irq_gate_off: assert property (s_enables_off |-> ##2 s_ch0_quiet)
        else $error("request stays up with its enable off");
    a_dtc_a_copy: assert property (HAS_EXT_RESET |->
        dtc_req_a_out == {irq_out[1].match_a_irq, irq_out[0].match_a_irq})
        else $error("transfer request A differs from match A request");
    a_dtc_b_copy: assert property (HAS_EXT_RESET |->
        dtc_req_b_out == {irq_out[1].match_b_irq, irq_out[0].match_b_irq})
        else $error("transfer request B differs from match B request");
    a_adc_one_cycle: assert property (adc_start_out |=> !adc_start_out)
        else $error("conversion start longer than one cycle");
    a_unit_hi_bare: assert property (!HAS_EXT_RESET |-> !adc_start_out &&
        dtc_req_a_out == 2'h0 && dtc_req_b_out == 2'h0 &&
        !irq_out[0].overflow_irq && !irq_out[1].overflow_irq)
        else $error("upper unit drives a request it lacks");
    a_read_idle: assert property (!$past(rd_in) |-> rdata_out == 8'h00)
        else $error("read data outside the answer cycle");
    a_reserved_one: assert property ($past(rd_in) &&
        $past(addr_in[7:1]) == 7'h01 |-> rdata_out[4])
        else $error("reserved status bit not read as one");
endmodule : ebct_timer_assertions

bind ebct_timer ebct_timer_assertions #(.HAS_EXT_RESET(HAS_EXT_RESET)) u_chk (
    .clk_in(clk_in), .arst_n_in(arst_n_in), .addr_in(addr_in), .wdata_in(wdata_in),
    .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
    .timer_output_pin_out(timer_output_pin_out),
    .timer_output_oe_n_out(timer_output_oe_n_out), .irq_out(irq_out),
    .dtc_req_a_out(dtc_req_a_out), .dtc_req_b_out(dtc_req_b_out),
    .adc_start_out(adc_start_out));

// [verification/tb_eight_bit_cascadable_timer.sv]
/*
 Bench of a lower and an upper timer unit.
 Assumes the bound checker and the request sink.
*/
`timescale 1ns/1ps
module tb_eight_bit_cascadable_timer;
    typedef struct packed {
        logic wr;
        logic [7:0] addr;
        logic [7:0] wdata;
        logic [7:0] exp;
    } ebct_tb_row_type;
    // Rows: optional write, then read back
    ebct_tb_row_type rows [9] = '{
        '{1'b0, 8'h00, 8'h00, 8'h00}, '{1'b0, 8'h02, 8'h00, 8'h10},
        '{1'b0, 8'h04, 8'h00, 8'hFF}, '{1'b0, 8'h07, 8'h00, 8'hFF},
        '{1'b0, 8'h08, 8'h00, 8'h00}, '{1'b1, 8'h0A, 8'h5A, 8'h00},
        '{1'b1, 8'h05, 8'h3C, 8'h3C}, '{1'b1, 8'h03, 8'h0F, 8'h1F},
        '{1'b1, 8'h03, 8'hE0, 8'h10}};
    logic clk_in = 1'b0;
    logic arst_n_in = 1'b0;
    logic [7:0] addr_in = 8'h00;
    logic [7:0] wdata_in = 8'h00;
    logic wr_in = 1'b0;
    logic rd_in = 1'b0;
    logic [1:0] ext_clk = 2'h0;
    logic [1:0] ext_rst = 2'h0;
    logic [7:0] rdata_out, rdata_b, rd_b, dtc_count, adc_count;
    logic [1:0] pin_out, oe_n_out, dtc_a, dtc_b, top_src;
    logic adc_start;
    ebct_pkg::ebct_irq_type [1:0] irq_out, irq_b;
    int bad_count = 0;
    int comparisons = 0;
    time t_first;

    // 40 MHz clock
    initial begin
        forever #12.5 clk_in = ~clk_in;
    end

    // Lower unit with reset pin clearing, upper unit without
    ebct_timer #(.HAS_EXT_RESET(1'b1)) u_dut (.clk_in(clk_in), .arst_n_in(arst_n_in),
        .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
        .rdata_out(rdata_out), .ext_clock_pin_in(ext_clk), .ext_counter_reset_pin_in(ext_rst),
        .timer_output_pin_out(pin_out), .timer_output_oe_n_out(oe_n_out), .irq_out(irq_out),
        .dtc_req_a_out(dtc_a), .dtc_req_b_out(dtc_b), .adc_start_out(adc_start));
    ebct_timer #(.HAS_EXT_RESET(1'b0)) u_dut_b (.clk_in(clk_in), .arst_n_in(arst_n_in),
        .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
        .rdata_out(rdata_b), .ext_clock_pin_in(ext_clk), .ext_counter_reset_pin_in(ext_rst),
        .timer_output_pin_out(), .timer_output_oe_n_out(), .irq_out(irq_b),
        .dtc_req_a_out(), .dtc_req_b_out(), .adc_start_out());
    ebct_req_sink u_sink (.clk_in(clk_in), .arst_n_in(arst_n_in), .irq_in(irq_out),
        .dtc_req_a_in(dtc_a), .dtc_req_b_in(dtc_b), .adc_start_in(adc_start),
        .dtc_count_out(dtc_count), .adc_count_out(adc_count), .top_source_out(top_src));

    task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask : check_byte

    task automatic check_bit(input logic got, input logic exp);
        check_byte({7'h00, got}, {7'h00, exp});
    endtask : check_bit

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_in);
        addr_in <= a;
        wdata_in <= d;
        wr_in <= 1'b1;
        @(posedge clk_in);
        wr_in <= 1'b0;
    endtask : wr_reg

    // Read data is taken in the single cycle after the strobe
    task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk_in);
        addr_in <= a;
        rd_in <= 1'b1;
        @(posedge clk_in);
        rd_in <= 1'b0;
        #1;
        rd_b = rdata_b;
        check_byte(rdata_out, exp);
    endtask : rd_reg

    // Two cycles per level keeps the far side inside its width limit
    task automatic pulse_ext(input int ch);
        @(posedge clk_in);
        ext_clk[ch] <= 1'b1;
        repeat (2) @(posedge clk_in);
        ext_clk[ch] <= 1'b0;
        repeat (2) @(posedge clk_in);
        #1;
    endtask : pulse_ext

    task automatic wait_match_a();
        int n;
        n = 0;
        while (irq_out[0].match_a_irq !== 1'b1 && n < 400) begin
            @(posedge clk_in);
            #1;
            n++;
        end
        if (n >= 400) bad_count++;
    endtask : wait_match_a

    // Read the flag as one, then write zero over it
    task automatic clear_a();
        rd_reg(8'h02, 8'h53);
        wr_reg(8'h02, 8'h13);
        repeat (2) @(posedge clk_in);
        #1;
        check_bit(irq_out[0].match_a_irq, 1'b0);
    endtask : clear_a

    task automatic tally_and_finish();
        $display("comparisons %0d, mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : tally_and_finish

    // Watchdog: tests need under 2000 cycles
    initial begin
        repeat (5000) @(posedge clk_in);
        bad_count++;
        tally_and_finish();
    end

    initial begin
        repeat (8) @(posedge clk_in);
        arst_n_in <= 1'b1;
        foreach (rows[i]) begin
            if (rows[i].wr) wr_reg(rows[i].addr, rows[i].wdata);
            rd_reg(rows[i].addr, rows[i].exp);
        end
        // Match A clear at 3 on clk/8, toggle, A/D enable: period 32 cycles
        wr_reg(8'h04, 8'h03);
        wr_reg(8'h02, 8'h13);
        wr_reg(8'h00, 8'h49);
        wait_match_a();
        t_first = $time;
        check_bit(pin_out[0], 1'b1);
        check_bit(oe_n_out[0], 1'b0);
        check_bit(dtc_a[0], 1'b1);
        check_byte({6'h00, top_src}, 8'h01);
        check_bit(irq_b[0].combined_match_irq, 1'b1);
        rd_reg(8'h08, 8'h00);
        clear_a();
        wait_match_a();
        check_byte(8'(($time - t_first) / 25), 8'h20);
        check_bit(pin_out[0], 1'b0);
        clear_a();
        wr_reg(8'h00, 8'h00);
        // Channel 1 on external rising edges wraps FE, FF, 00
        wr_reg(8'h01, 8'h25);
        wr_reg(8'h09, 8'hFE);
        pulse_ext(1);
        check_bit(irq_out[1].overflow_irq, 1'b0);
        pulse_ext(1);
        check_bit(irq_out[1].overflow_irq, 1'b1);
        check_bit(dtc_a[1] | dtc_b[1], 1'b0);
        rd_reg(8'h09, 8'h00);
        // Reset pin level clears the lower unit only
        wr_reg(8'h01, 8'h1D);
        wr_reg(8'h09, 8'h40);
        @(posedge clk_in);
        ext_rst[1] <= 1'b1;
        repeat (2) @(posedge clk_in);
        ext_rst[1] <= 1'b0;
        rd_reg(8'h09, 8'h00);
        check_byte(rd_b, 8'h40);
        // 16-bit pair matching 0102, with channel 1 asking to clear at 02
        wr_reg(8'h04, 8'h01);
        wr_reg(8'h05, 8'h02);
        wr_reg(8'h08, 8'h00);
        wr_reg(8'h09, 8'hFE);
        wr_reg(8'h01, 8'h0D);
        wr_reg(8'h00, 8'h4C);
        repeat (4) pulse_ext(1);
        rd_reg(8'h08, 8'h01);
        rd_reg(8'h09, 8'h02);
        check_bit(irq_out[0].match_a_irq, 1'b0);
        pulse_ext(1);
        check_bit(irq_out[0].match_a_irq, 1'b1);
        rd_reg(8'h08, 8'h00);
        rd_reg(8'h09, 8'h00);
        // Channel 1 flags: low-byte match A and B, overflow
        rd_reg(8'h03, 8'hF0);
        check_byte(adc_count, 8'h03);
        check_byte(dtc_count, 8'h03);
        tally_and_finish();
    end
endmodule : tb_eight_bit_cascadable_timer

// [verilog/ebct_map.svh]
/*
 Register offsets, field positions, reset values and timing counts of the
 cascadable 8-bit timer pair. Assumes inclusion by bare name from a design
 file that also compiles ebct_pkg.
*/
`ifndef EBCT_MAP_SVH
`define EBCT_MAP_SVH

// Register offsets (byte addresses, 8-bit registers)
`define EBCT_TCR0_OFS 8'h00
`define EBCT_TCR1_OFS 8'h01
`define EBCT_CSR0_OFS 8'h02
`define EBCT_CSR1_OFS 8'h03
`define EBCT_MCA0_OFS 8'h04
`define EBCT_MCA1_OFS 8'h05
`define EBCT_MCB0_OFS 8'h06
`define EBCT_MCB1_OFS 8'h07
`define EBCT_CNT0_OFS 8'h08
`define EBCT_CNT1_OFS 8'h09

// Timer control register fields
`define EBCT_CTL_CKS_LSB 0
`define EBCT_CTL_CCLR_LSB 3
`define EBCT_CTL_OVIE_BIT 5
`define EBCT_CTL_CMIEA_BIT 6
`define EBCT_CTL_CMIEB_BIT 7

// Control/status register fields
`define EBCT_CSR_OSA_LSB 0
`define EBCT_CSR_OSB_LSB 2
`define EBCT_CSR_RSV_BIT 4
`define EBCT_CSR_OFL_BIT 5
`define EBCT_CSR_MFA_BIT 6
`define EBCT_CSR_MFB_BIT 7

// Field codes
`define EBCT_CKS_STOP 3'h0
`define EBCT_CKS_CASCADE 3'h4
`define EBCT_CKS_EXT_RISE 3'h5
`define EBCT_CKS_EXT_FALL 3'h6
`define EBCT_CKS_EXT_BOTH 3'h7
`define EBCT_CCLR_NONE 2'h0
`define EBCT_CCLR_MATCH_A 2'h1
`define EBCT_CCLR_MATCH_B 2'h2
`define EBCT_CCLR_EXT 2'h3

// Reset values and count maximum
`define EBCT_CTL_RST 8'h00
`define EBCT_MC_RST 8'hFF
`define EBCT_CNT_RST 8'h00
`define EBCT_CNT_MAX 8'hFF

// Internal prescaler masks: dividers minus one, in peripheral clocks
`define EBCT_DIV_CODE1 8'h07
`define EBCT_DIV_CODE2 8'h1F
`define EBCT_DIV_CODE3 8'hFF

`endif

// [verilog/ebct_pkg.sv]
/*
 Types of the cascadable 8-bit timer pair. Assumes nothing of its
 surroundings.
*/
package ebct_pkg;

    // Per-channel control settings
    typedef struct packed {
        logic cmie_b;
        logic cmie_a;
        logic ovie;
        logic [1:0] clear_sel;
        logic [2:0] clock_sel;
    } ebct_ctl_type;

    // Per-channel request outputs
    typedef struct packed {
        logic match_a_irq;
        logic match_b_irq;
        logic overflow_irq;
        logic combined_match_irq;
    } ebct_irq_type;

    // Cascade mode of the pair
    typedef enum logic [2:0] {
        EBCT_MODE_SPLIT = 3'b001,
        EBCT_MODE_WIDE = 3'b010,
        EBCT_MODE_MATCH_COUNT = 3'b100
    } ebct_mode_type;

endpackage : ebct_pkg

// [verilog/ebct_timer.sv]
/*
 One unit of the cascadable 8-bit timer: two up-counting channels with
 compare match A/B, overflow, external clock and reset pins, 16-bit and
 match-count cascade, request outputs and A/D trigger.
 Assumes pins synchronous to clk_in and a master following the plain
 register port (read data one cycle after the read strobe).
*/
// The placing of the registers and the strobed register port were left to the implementer.
// Summary of operation
// - Match sets its A or B flag
// - Match takes effect at next count clock
// - Match updates output pin per select field
// - Clear field selects clear on match A/B
// - External reset clears on pin level
// - External reset clear only in units 0,1
// - Overflow flag on wrap from max to zero
// - Cascade code in one channel only cascades pair
// - Channel 0 cascade code forms 16-bit counter
// - Wide mode flags: full and low-byte match
// - Wide match clear clears both bytes
// - Wide mode ignores channel 1 clear field
// - Wide mode pins follow wide/low matches
// - Channel 1 cascade counts channel 0 match A
// - Units 0,1: separate gated match/overflow requests
// - Units 0,1: match requests start transfer controller
// - Units 2,3: one combined match request
// - Units 0,1: channel 0 match A with enable triggers A/D
// - Output select: keep, low, high, toggle
// - Clear field 01 clears on match A
// - Output low from reset, off while selects zero
// - Flags clear by read-1 then write-0
`timescale 1ns/1ps
`include "ebct_map.svh"

module ebct_timer #(
    parameter bit HAS_EXT_RESET = 1'b1
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic arst_n_in,
    // Register port
    input wire logic [7:0] addr_in,
    input wire logic [7:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [7:0] rdata_out,
    // Pins, one bit per channel
    input wire logic [1:0] ext_clock_pin_in,
    input wire logic [1:0] ext_counter_reset_pin_in,
    output logic [1:0] timer_output_pin_out,
    output logic [1:0] timer_output_oe_n_out,
    // Requests to interrupt controller, transfer controller and A/D
    output ebct_pkg::ebct_irq_type [1:0] irq_out,
    output logic [1:0] dtc_req_a_out,
    output logic [1:0] dtc_req_b_out,
    output logic adc_start_out
);

    ebct_pkg::ebct_ctl_type [1:0] timer_control_reg;
    logic [1:0] match_a_flag;
    logic [1:0] match_b_flag;
    logic [1:0] overflow_flag;
    logic [1:0][3:0] out_sel;
    logic adc_trigger_enable;
    logic [1:0][7:0] match_constant_a;
    logic [1:0][7:0] match_constant_b;
    logic [1:0][7:0] count_value;
    logic [1:0] ext_clk_q;
    logic [1:0] ext_rst_q;
    logic [1:0] flag_a_seen;
    logic [1:0] flag_b_seen;
    logic [1:0] flag_o_seen;
    logic [7:0] prescale;
    logic [1:0] match_a_q;
    ebct_pkg::ebct_mode_type mode;

    // Mode decode: the cascade code in exactly one channel ties the pair
    wire logic wide_sel = timer_control_reg[0].clock_sel == `EBCT_CKS_CASCADE;
    wire logic mcnt_sel = timer_control_reg[1].clock_sel == `EBCT_CKS_CASCADE;
    wire logic wide_mode = wide_sel && !mcnt_sel;
    wire logic mcnt_mode = mcnt_sel && !wide_sel;

    // Match terms; wide match for channel 0 needs both bytes equal
    wire logic [1:0] eq_a;
    wire logic [1:0] eq_b;
    assign eq_a[1] = count_value[1] == match_constant_a[1];
    assign eq_b[1] = count_value[1] == match_constant_b[1];
    assign eq_a[0] = (count_value[0] == match_constant_a[0]) && (!wide_mode || eq_a[1]);
    assign eq_b[0] = (count_value[0] == match_constant_b[0]) && (!wide_mode || eq_b[1]);

    // Register decode
    wire logic [1:0] wr_ctl;
    wire logic [1:0] wr_csr;
    wire logic [1:0] wr_mca;
    wire logic [1:0] wr_mcb;
    wire logic [1:0] wr_cnt;
    wire logic [1:0] rd_csr;
    assign wr_ctl = {wr_in && addr_in == `EBCT_TCR1_OFS, wr_in && addr_in == `EBCT_TCR0_OFS};
    assign wr_csr = {wr_in && addr_in == `EBCT_CSR1_OFS, wr_in && addr_in == `EBCT_CSR0_OFS};
    assign wr_mca = {wr_in && addr_in == `EBCT_MCA1_OFS, wr_in && addr_in == `EBCT_MCA0_OFS};
    assign wr_mcb = {wr_in && addr_in == `EBCT_MCB1_OFS, wr_in && addr_in == `EBCT_MCB0_OFS};
    assign wr_cnt = {wr_in && addr_in == `EBCT_CNT1_OFS, wr_in && addr_in == `EBCT_CNT0_OFS};
    assign rd_csr = {rd_in && addr_in == `EBCT_CSR1_OFS, rd_in && addr_in == `EBCT_CSR0_OFS};

    // Per-channel clock, match, clear and next-state logic
    logic [1:0] tick;
    logic [1:0] hit_a;
    logic [1:0] hit_b;
    logic [1:0] clr;
    logic [1:0] wrap;
    logic [1:0][7:0] next_count;
    logic [1:0] next_out;
    logic [1:0][7:0] csr_view;
    logic [1:0] int_tick;
    genvar ch;
    generate
        for (ch = 0; ch < 2; ch = ch + 1) begin : g_ch
            wire logic [2:0] cks = timer_control_reg[ch].clock_sel;
            wire logic [1:0] ccl = timer_control_reg[ch].clear_sel;
            wire logic ext_rise = ext_clock_pin_in[ch] && !ext_clk_q[ch];
            wire logic ext_fall = !ext_clock_pin_in[ch] && ext_clk_q[ch];
            wire logic rst_rise = ext_counter_reset_pin_in[ch] && !ext_rst_q[ch];
            // Internal sources from one shared prescaler
            assign int_tick[ch] = (cks == 3'h1 && (prescale & `EBCT_DIV_CODE1) == 8'h00)
                || (cks == 3'h2 && (prescale & `EBCT_DIV_CODE2) == 8'h00)
                || (cks == 3'h3 && prescale == `EBCT_DIV_CODE3);
            // Raw count clock; the pin is sampled as-is so narrow pulses may be missed
            wire logic own_tick = int_tick[ch]
                || (cks == `EBCT_CKS_EXT_RISE && ext_rise)
                || (cks == `EBCT_CKS_EXT_FALL && ext_fall)
                || (cks == `EBCT_CKS_EXT_BOTH && (ext_rise || ext_fall));
            if (ch == 1) begin : g_lo
                // Low byte counts by own clock in wide mode, match A in match-count mode
                assign tick[1] = mcnt_mode ? match_a_q[0] : (own_tick && cks != `EBCT_CKS_CASCADE);
            end else begin : g_hi
                assign tick[0] = wide_mode ? (tick[1] && count_value[1] == `EBCT_CNT_MAX)
                    : (own_tick && cks != `EBCT_CKS_CASCADE);
            end
            // Match fires on the count clock that ends the equal state
            assign hit_a[ch] = eq_a[ch] && (wide_mode && ch == 0 ? tick[1] : tick[ch]);
            assign hit_b[ch] = eq_b[ch] && (wide_mode && ch == 0 ? tick[1] : tick[ch]);
            // Clear sources; channel 1's field is dead in wide mode
            wire logic ext_clr = HAS_EXT_RESET && ccl == `EBCT_CCLR_EXT
                && ext_counter_reset_pin_in[ch];
            wire logic own_clr = (ccl == `EBCT_CCLR_MATCH_A && hit_a[ch])
                || (ccl == `EBCT_CCLR_MATCH_B && hit_b[ch]) || ext_clr;
            wire logic wide_clr = (timer_control_reg[0].clear_sel == `EBCT_CCLR_MATCH_A && hit_a[0])
                || (timer_control_reg[0].clear_sel == `EBCT_CCLR_MATCH_B && hit_b[0])
                || (HAS_EXT_RESET && timer_control_reg[0].clear_sel == `EBCT_CCLR_EXT
                && ext_counter_reset_pin_in[0]);
            assign clr[ch] = wide_mode ? wide_clr : own_clr;
            assign wrap[ch] = tick[ch] && !clr[ch] && count_value[ch] == `EBCT_CNT_MAX;
            // Clear beats write, write beats increment
            always_comb begin
                if (clr[ch]) begin
                    next_count[ch] = `EBCT_CNT_RST;
                end else if (wr_cnt[ch]) begin
                    next_count[ch] = wdata_in;
                end else if (tick[ch]) begin
                    next_count[ch] = count_value[ch] + 8'h01;
                end else begin
                    next_count[ch] = count_value[ch];
                end
            end
            // Output priority: toggle, high, low, keep
            wire logic [1:0] osa = out_sel[ch][1:0];
            wire logic [1:0] osb = out_sel[ch][3:2];
            wire logic [1:0] sa = hit_a[ch] ? osa : 2'h0;
            wire logic [1:0] sb = hit_b[ch] ? osb : 2'h0;
            always_comb begin
                if (sa == 2'h3 || sb == 2'h3) begin
                    next_out[ch] = !timer_output_pin_out[ch];
                end else if (sa == 2'h2 || sb == 2'h2) begin
                    next_out[ch] = 1'b1;
                end else if (sa == 2'h1 || sb == 2'h1) begin
                    next_out[ch] = 1'b0;
                end else begin
                    next_out[ch] = timer_output_pin_out[ch];
                end
            end
            assign csr_view[ch] = {match_b_flag[ch], match_a_flag[ch], overflow_flag[ch],
                1'b1, out_sel[ch]};

            // Flags: set wins over a software clear in the same cycle
            always_ff @(posedge clk_in or negedge arst_n_in) begin
                if (!arst_n_in) begin
                    match_a_flag[ch] <= 1'b0;
                    match_b_flag[ch] <= 1'b0;
                    overflow_flag[ch] <= 1'b0;
                end else begin
                    match_a_flag[ch] <= hit_a[ch] || (match_a_flag[ch] && !(wr_csr[ch]
                        && !wdata_in[`EBCT_CSR_MFA_BIT] && flag_a_seen[ch]));
                    match_b_flag[ch] <= hit_b[ch] || (match_b_flag[ch] && !(wr_csr[ch]
                        && !wdata_in[`EBCT_CSR_MFB_BIT] && flag_b_seen[ch]));
                    overflow_flag[ch] <= wrap[ch] || (overflow_flag[ch] && !(wr_csr[ch]
                        && !wdata_in[`EBCT_CSR_OFL_BIT] && flag_o_seen[ch]));
                end
            end

            // Remember that a flag was read as 1 before the clearing write
            always_ff @(posedge clk_in or negedge arst_n_in) begin
                if (!arst_n_in) begin
                    flag_a_seen[ch] <= 1'b0;
                    flag_b_seen[ch] <= 1'b0;
                    flag_o_seen[ch] <= 1'b0;
                end else if (rd_csr[ch]) begin
                    flag_a_seen[ch] <= match_a_flag[ch];
                    flag_b_seen[ch] <= match_b_flag[ch];
                    flag_o_seen[ch] <= overflow_flag[ch];
                end else if (wr_csr[ch]) begin
                    flag_a_seen[ch] <= 1'b0;
                    flag_b_seen[ch] <= 1'b0;
                    flag_o_seen[ch] <= 1'b0;
                end
            end

            // Configuration, constants, counter and pin
            always_ff @(posedge clk_in or negedge arst_n_in) begin
                if (!arst_n_in) begin
                    timer_control_reg[ch] <= `EBCT_CTL_RST;
                    out_sel[ch] <= 4'h0;
                    match_constant_a[ch] <= `EBCT_MC_RST;
                    match_constant_b[ch] <= `EBCT_MC_RST;
                    count_value[ch] <= `EBCT_CNT_RST;
                    timer_output_pin_out[ch] <= 1'b0;
                    timer_output_oe_n_out[ch] <= 1'b1;
                    ext_clk_q[ch] <= 1'b0;
                    ext_rst_q[ch] <= 1'b0;
                    match_a_q[ch] <= 1'b0;
                end else begin
                    if (wr_ctl[ch]) begin
                        timer_control_reg[ch] <= wdata_in;
                    end
                    if (wr_csr[ch]) begin
                        out_sel[ch] <= wdata_in[3:0];
                    end
                    if (wr_mca[ch]) begin
                        match_constant_a[ch] <= wdata_in;
                    end
                    if (wr_mcb[ch]) begin
                        match_constant_b[ch] <= wdata_in;
                    end
                    count_value[ch] <= next_count[ch];
                    timer_output_pin_out[ch] <= next_out[ch];
                    timer_output_oe_n_out[ch] <= out_sel[ch] == 4'h0;
                    ext_clk_q[ch] <= ext_clock_pin_in[ch];
                    ext_rst_q[ch] <= ext_counter_reset_pin_in[ch];
                    match_a_q[ch] <= hit_a[ch];
                end
            end

            // Requests: separate lines in units 0,1, one merged line otherwise
            always_ff @(posedge clk_in or negedge arst_n_in) begin
                if (!arst_n_in) begin
                    irq_out[ch] <= 4'h0;
                    dtc_req_a_out[ch] <= 1'b0;
                    dtc_req_b_out[ch] <= 1'b0;
                end else begin
                    irq_out[ch].match_a_irq <= HAS_EXT_RESET && next_a_lvl(ch);
                    irq_out[ch].match_b_irq <= HAS_EXT_RESET && next_b_lvl(ch);
                    irq_out[ch].overflow_irq <= HAS_EXT_RESET
                        && timer_control_reg[ch].ovie && (overflow_flag[ch] || wrap[ch]);
                    irq_out[ch].combined_match_irq <= !HAS_EXT_RESET
                        && (next_a_lvl(ch) || next_b_lvl(ch));
                    dtc_req_a_out[ch] <= HAS_EXT_RESET && next_a_lvl(ch);
                    dtc_req_b_out[ch] <= HAS_EXT_RESET && next_b_lvl(ch);
                end
            end
        end
    endgenerate

    // Enabled match request levels follow the flag, including its setting edge
    function automatic logic next_a_lvl(input int idx);
        next_a_lvl = timer_control_reg[idx].cmie_a && (match_a_flag[idx] || hit_a[idx]);
    endfunction : next_a_lvl

    function automatic logic next_b_lvl(input int idx);
        next_b_lvl = timer_control_reg[idx].cmie_b && (match_b_flag[idx] || hit_b[idx]);
    endfunction : next_b_lvl

    // Read mux: unmapped offsets read as zero
    wire logic [7:0] rd_mux =
        addr_in == `EBCT_TCR0_OFS ? timer_control_reg[0] :
        addr_in == `EBCT_TCR1_OFS ? timer_control_reg[1] :
        addr_in == `EBCT_CSR0_OFS ? csr_view[0] :
        addr_in == `EBCT_CSR1_OFS ? csr_view[1] :
        addr_in == `EBCT_MCA0_OFS ? match_constant_a[0] :
        addr_in == `EBCT_MCA1_OFS ? match_constant_a[1] :
        addr_in == `EBCT_MCB0_OFS ? match_constant_b[0] :
        addr_in == `EBCT_MCB1_OFS ? match_constant_b[1] :
        addr_in == `EBCT_CNT0_OFS ? count_value[0] :
        addr_in == `EBCT_CNT1_OFS ? count_value[1] : 8'h00;
    wire ebct_pkg::ebct_mode_type next_mode = wide_mode ? ebct_pkg::EBCT_MODE_WIDE :
        mcnt_mode ? ebct_pkg::EBCT_MODE_MATCH_COUNT : ebct_pkg::EBCT_MODE_SPLIT;

    // Shared prescaler, read data, A/D trigger and mode state
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            prescale <= 8'h00;
            rdata_out <= 8'h00;
            adc_trigger_enable <= 1'b0;
            adc_start_out <= 1'b0;
            mode <= ebct_pkg::EBCT_MODE_SPLIT;
        end else begin
            prescale <= prescale + 8'h01;
            rdata_out <= rd_in ? rd_mux : 8'h00;
            if (wr_csr[0]) begin
                adc_trigger_enable <= wdata_in[`EBCT_CSR_RSV_BIT];
            end
            adc_start_out <= HAS_EXT_RESET && adc_trigger_enable && hit_a[0];
            mode <= next_mode;
        end
    end

endmodule : ebct_timer
